// file: rtl/rsa_abort_flags.sv
// bank of sticky abort-cause flags with a software clear
// assumes detect and clr are one-cycle pulses from the parent
`timescale 1ns/10ps
module rsa_abort_flags #(
  parameter int N = 2,
  parameter logic [1:0] REASSERT = 2'h2
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [N-1:0] detect, // abort attempt seen, pulse
  input wire logic [N-1:0] cause, // abort cause still present, level
  input wire logic clr, // software clear, pulse
  output logic [N-1:0] flags // sticky flags
);
  import rsa_pkg::*;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      logic flag_reg;
      logic flag_next;
      logic again_reg;
      // a clear while the cause stands drops the flag for one cycle only where REASSERT[i] is set
      wire again_next = REASSERT[i] & clr & flag_reg & cause[i];
      // detection wins over a clear in the same cycle
      assign flag_next = detect[i] | again_reg | (flag_reg & ~clr);
      assign flags[i] = flag_reg;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flag_reg <= 1'b0;
          again_reg <= 1'b0;
        end else begin
          flag_reg <= flag_next;
          again_reg <= again_next;
        end
      end
    end
  endgenerate
endmodule

// file: rtl/rsa_axil_slave.sv
// AXI4-Lite slave front end: one write and one read under way at a time
// assumes the parent decodes addresses and supplies read data combinationally
`timescale 1ns/10ps
module rsa_axil_slave (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output rsa_pkg::rsa_wr_t wr, // held write request
  output logic wr_fire, // one-cycle write strobe
  input wire logic wr_ok, // write address is mapped
  output logic rd_fire, // one-cycle read strobe
  input wire logic [31:0] rd_data, // read data for araddr
  input wire logic rd_ok // read address is mapped
);
  import rsa_pkg::*;

  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] addr_reg;
  logic [31:0] data_reg;
  logic [3:0] strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  assign awready = ~aw_hold_reg;
  assign wready = ~w_hold_reg;
  assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign wr = '{addr: addr_reg, data: data_reg, strb: strb_reg};
  assign arready = ~rvalid_reg;
  assign rd_fire = arvalid & arready;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      addr_reg <= 8'h00;
      data_reg <= 32'h0000_0000;
      strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        addr_reg <= awaddr;
      end else if (wr_fire) begin
        aw_hold_reg <= 1'b0;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        data_reg <= wdata;
        strb_reg <= wstrb;
      end else if (wr_fire) begin
        w_hold_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= rd_ok ? rd_data : 32'h0000_0000;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule

// file: rtl/rsa_pkg.sv
// package of the restart abort-source block: offsets, field positions, reset values, carriers
// assumes a 32-bit AXI4-Lite register bus with byte addresses on 8 bits
package rsa_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TARGET = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_ABORT_SRC = 8'h0C;
  localparam logic [7:0] OFF_CLR_ABORT = 8'h10;
  localparam logic [7:0] OFF_INT_STAT = 8'h14;
  localparam logic [7:0] OFF_INT_MASK = 8'h18;

  // field positions
  localparam int CTRL_HS_BIT = 2;
  localparam int CTRL_RESTART_BIT = 5;
  localparam int TAR_GC_START_BIT = 10;
  localparam int TAR_START_BYTE_OR_GC_SELECT_BIT = 11;
  localparam int CMD_START_BIT = 0;
  localparam int ABRT_HS_BIT = 8;
  localparam int ABRT_SBYTE_BIT = 9;
  localparam int INT_TX_ABORT_BIT = 0;

  // abort flag vector: index 0 high-speed, index 1 start byte
  localparam int N_FLAGS = 2;
  localparam int FLAG_HS = 0;
  localparam int FLAG_SBYTE = 1;
  localparam logic [1:0] REASSERT_MASK = 2'h2;

  // reset values and writable-bit masks
  localparam logic [31:0] CTRL_RST = 32'h0000_0020;
  localparam logic [31:0] TARGET_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0024;
  localparam logic [31:0] TARGET_WMASK = 32'h0000_0C00;
  localparam logic [31:0] INT_WMASK = 32'h0000_0001;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one register write as taken from the bus
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } rsa_wr_t;

  // configuration bits that decide whether an attempt aborts
  typedef struct packed {
    logic restart_en;
    logic speed_hs;
    logic start_byte_or_gc_select;
    logic gc_start;
  } rsa_cfg_t;
endpackage

// file: rtl/rsa_restart_abort.sv
// top of the restart abort-source block: register file, attempt detection, interrupt
// assumes an AXI4-Lite master on the system clock; one clock, synchronous reset
//
// Overview of operation
// - start byte with restart off sets flag
// - clear with start-byte cause present: reassert next cycle
// - cause removed: ordinary clear works
// - high-speed attempt with restart off sets flag
// - high-speed flag reads one when attempted
// - any abort raises transmit-abort interrupt
`timescale 1ns/10ps
module rsa_restart_abort (
  input wire logic aclk, // system clock, 50 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic transmit_abort_event, // abort pulse to the rest of the unit
  output logic irq // level interrupt
);
  import rsa_pkg::*;

  rsa_wr_t wr;
  logic wr_fire;
  logic rd_fire;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_data;
  logic [31:0] controller_config_reg;
  logic [31:0] target_address_control_reg;
  logic [31:0] int_stat_reg;
  logic [31:0] int_mask_reg;
  logic [31:0] int_stat_next;
  logic event_reg;
  logic [N_FLAGS-1:0] flags;
  logic [N_FLAGS-1:0] detect;
  logic [N_FLAGS-1:0] cause;
  rsa_cfg_t cfg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = res & wmask;
  endfunction

  rsa_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr(wr),
    .wr_fire(wr_fire),
    .wr_ok(wr_ok),
    .rd_fire(rd_fire),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // write decode
  wire wr_ctrl = wr_fire & (wr.addr == OFF_CTRL);
  wire wr_target = wr_fire & (wr.addr == OFF_TARGET);
  wire wr_cmd = wr_fire & (wr.addr == OFF_CMD) & wr.strb[0];
  wire wr_mask = wr_fire & (wr.addr == OFF_INT_MASK);
  assign wr_ok = (wr.addr == OFF_CTRL) | (wr.addr == OFF_TARGET) | (wr.addr == OFF_CMD)
    | (wr.addr == OFF_INT_MASK);

  // read decode; read-only registers accept reads only
  wire rd_ctrl = s_axi_araddr == OFF_CTRL;
  wire rd_target = s_axi_araddr == OFF_TARGET;
  wire rd_cmd = s_axi_araddr == OFF_CMD;
  wire rd_src = s_axi_araddr == OFF_ABORT_SRC;
  wire rd_clr = s_axi_araddr == OFF_CLR_ABORT;
  wire rd_stat = s_axi_araddr == OFF_INT_STAT;
  wire rd_mask = s_axi_araddr == OFF_INT_MASK;
  assign rd_ok = rd_ctrl | rd_target | rd_cmd | rd_src | rd_clr | rd_stat | rd_mask;
  wire [31:0] abort_src = {22'h00_0000, flags, 8'h00};
  wire [31:0] clr_val = {31'h0000_0000, |flags};
  assign rd_data = rd_ctrl ? controller_config_reg
    : rd_target ? target_address_control_reg
    : rd_src ? abort_src
    : rd_clr ? clr_val
    : rd_stat ? int_stat_reg
    : rd_mask ? int_mask_reg
    : 32'h0000_0000;

  // configuration seen by the detectors
  assign cfg.restart_en = controller_config_reg[CTRL_RESTART_BIT];
  assign cfg.speed_hs = controller_config_reg[CTRL_HS_BIT];
  assign cfg.start_byte_or_gc_select = target_address_control_reg[TAR_START_BYTE_OR_GC_SELECT_BIT];
  assign cfg.gc_start = target_address_control_reg[TAR_GC_START_BIT];

  // a cause stands while its configuration would abort the next attempt;
  // software clears the start-byte cause through restart enable, start_byte_or_gc_select or gc/start, the high-speed one through restart enable or high speed
  assign cause[FLAG_SBYTE] = ~cfg.restart_en & cfg.start_byte_or_gc_select & cfg.gc_start;
  assign cause[FLAG_HS] = ~cfg.restart_en & cfg.speed_hs;
  wire start_attempt = wr_cmd & wr.data[CMD_START_BIT];
  assign detect[FLAG_SBYTE] = start_attempt & cause[FLAG_SBYTE];
  assign detect[FLAG_HS] = start_attempt & cause[FLAG_HS];

  // reading the abort clear register clears the abort source bits; the start-byte bit sets again a cycle later while its cause stands
  wire abort_clr = rd_fire & rd_clr;

  rsa_abort_flags #(
    .N(N_FLAGS),
    .REASSERT(REASSERT_MASK)
  ) u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .detect(detect),
    .cause(cause),
    .clr(abort_clr),
    .flags(flags)
  );

  // interrupt status: sticky, read-clear, a new event wins over the clear
  wire abort_now = |detect;
  wire stat_clr = rd_fire & (rd_stat | rd_clr);
  always_comb begin
    int_stat_next = stat_clr ? 32'h0000_0000 : int_stat_reg;
    int_stat_next[INT_TX_ABORT_BIT] = abort_now | int_stat_next[INT_TX_ABORT_BIT];
  end
  assign irq = |(int_stat_reg & int_mask_reg);
  assign transmit_abort_event = event_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      controller_config_reg <= CTRL_RST;
      target_address_control_reg <= TARGET_RST;
      int_mask_reg <= MASK_RST;
    end else begin
      if (wr_ctrl) begin
        controller_config_reg <= merge(controller_config_reg, wr.data, wr.strb, CTRL_WMASK);
      end
      if (wr_target) begin
        target_address_control_reg <= merge(target_address_control_reg, wr.data, wr.strb,
                                            TARGET_WMASK);
      end
      if (wr_mask) begin
        int_mask_reg <= merge(int_mask_reg, wr.data, wr.strb, INT_WMASK);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat_reg <= 32'h0000_0000;
      event_reg <= 1'b0;
    end else begin
      int_stat_reg <= int_stat_next;
      event_reg <= abort_now;
    end
  end
endmodule

// file: verification/rsa_axil_master.sv
// software side model: AXI4-Lite master with one write and one read task
// assumes the slave on the same clock; waits are cut short only by the bench watchdog
`timescale 1ns/10ps
module rsa_axil_master (
  input wire logic aclk, // system clock
  output logic [7:0] s_axi_awaddr, // write address
  output logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  output logic [31:0] s_axi_wdata, // write data
  output logic [3:0] s_axi_wstrb, // byte enables
  output logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  output logic s_axi_bready, // write response ready
  output logic [7:0] s_axi_araddr, // read address
  output logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  output logic s_axi_rready // read data ready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// file: verification/rsa_restart_abort_asserts.sv
// checker of the restart abort-source top: bus answers, abort event, interrupt, flag layout
// assumes it is bound to rsa_restart_abort and sees only its ports
`timescale 1ns/10ps
module rsa_restart_abort_asserts (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic transmit_abort_event, // abort pulse
  input wire logic irq // level interrupt
);
  import rsa_pkg::*;
  logic [7:0] rd_addr_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_addr_reg <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_ar_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read not answered next cycle");
  property p_event_pulse; transmit_abort_event |=> !transmit_abort_event; endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("abort event too long");
  property p_event_cmd; $rose(transmit_abort_event) |-> s_axi_bvalid; endproperty
  a_event_cmd: assert property (p_event_cmd) else $error("abort event without write");
  property p_irq_rise; $rose(irq) |-> s_axi_bvalid; endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without write");
  property p_src_bits; s_axi_rvalid && rd_addr_reg == OFF_ABORT_SRC
    |-> s_axi_rdata[31:10] == 22'h0 && s_axi_rdata[7:0] == 8'h00; endproperty
  a_src_bits: assert property (p_src_bits) else $error("abort source stray bits");
  property p_unmapped; s_axi_rvalid && rd_addr_reg > OFF_INT_MASK
    |-> s_axi_rdata == 32'h0 && s_axi_rresp == RESP_SLVERR; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_clr_bits; s_axi_rvalid && rd_addr_reg == OFF_CLR_ABORT
    |-> s_axi_rdata[31:1] == 31'h0; endproperty
  a_clr_bits: assert property (p_clr_bits) else $error("clear read stray bits");
  c_event: cover property (transmit_abort_event);
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind rsa_restart_abort rsa_restart_abort_asserts u_chk (.aclk, .aresetn, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .transmit_abort_event, .irq);

// file: verification/tb_rsa_restart_abort.sv
// bench of the restart abort-source top: random attempts, clears with and without cause
// assumes the checker is bound separately; one 50 MHz clock
`timescale 1ns/10ps
module tb_rsa_restart_abort;
  import rsa_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, irq;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic transmit_abort_event, msk, keep;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, lfsr, d;
  logic [3:0] s_axi_wstrb, cfg;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, f;
  int n_fail, n_tests, n_event, ev0;
  rsa_restart_abort uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .transmit_abort_event, .irq);
  rsa_axil_master mst (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // counts abort pulses seen on the event output
  always_ff @(posedge aclk) begin
    if (!aresetn) n_event <= 0;
    else if (transmit_abort_event) n_event <= n_event + 1;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // cfg: bit3 restart enable, bit2 high speed, bit1 start_byte_or_gc_select, bit0 general call/start
  function automatic logic [1:0] exp_flags(input logic [3:0] c);
    return {!c[3] & c[1] & c[0], !c[3] & c[2]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
  initial begin
    aresetn = 1'b0;
    n_fail = 0;
    n_tests = 0;
    lfsr = 32'h0926;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    mst.rd(OFF_CTRL, d, r); check(d, CTRL_RST);
    mst.rd(OFF_ABORT_SRC, d, r); check(d, 32'h0);
    mst.wr(OFF_ABORT_SRC, 32'h300, r); check({30'h0, r}, {30'h0, RESP_SLVERR});
    mst.rd(OFF_ABORT_SRC, d, r); check(d, 32'h0);
    mst.rd(8'h40, d, r); check({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    mst.rd(OFF_CMD, d, r); check(d, 32'h0);
    for (int i = 0; i < 16; i++) begin
      lfsr = lfsr_next(lfsr);
      cfg = (i == 0) ? 4'h7 : (i == 1) ? 4'h3 : lfsr[3:0];
      keep = (i == 0) ? 1'b1 : lfsr[4];
      msk = lfsr[5];
      f = exp_flags(cfg);
      mst.wr(OFF_CTRL, {26'h0, cfg[3], 2'h0, cfg[2], 2'h0}, r);
      mst.wr(OFF_TARGET, {20'h0, cfg[1], cfg[0], 10'h0}, r);
      mst.wr(OFF_INT_MASK, {31'h0, msk}, r);
      ev0 = n_event;
      mst.wr(OFF_CMD, 32'h1, r);
      check({31'h0, irq}, {31'h0, |f & msk});
      mst.rd(OFF_ABORT_SRC, d, r); check(d, {22'h0, f, 8'h0});
      check(n_event - ev0, {31'h0, |f});
      mst.rd(OFF_INT_STAT, d, r); check(d, {31'h0, |f});
      if (!keep) mst.wr(OFF_CTRL, 32'h20, r);
      mst.rd(OFF_CLR_ABORT, d, r); check(d, {31'h0, |f});
      mst.rd(OFF_ABORT_SRC, d, r); check(d, {22'h0, f[1] & keep, 9'h0});
      mst.wr(OFF_CTRL, 32'h20, r);
      mst.rd(OFF_CLR_ABORT, d, r); check(d, {31'h0, f[1] & keep});
      mst.rd(OFF_ABORT_SRC, d, r); check(d, 32'h0);
    end
    // set flag survives a software write, then a mid-run reset drops it
    mst.wr(OFF_CTRL, 32'h0, r);
    mst.wr(OFF_TARGET, 32'hC00, r);
    mst.wr(OFF_INT_MASK, 32'h1, r);
    mst.wr(OFF_CMD, 32'h1, r);
    mst.wr(OFF_ABORT_SRC, 32'h0, r); check({30'h0, r}, {30'h0, RESP_SLVERR});
    mst.rd(OFF_ABORT_SRC, d, r); check(d, 32'h200);
    check({31'h0, irq}, 32'h1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    check({31'h0, irq}, 32'h0);
    mst.rd(OFF_ABORT_SRC, d, r); check(d, 32'h0);
    mst.rd(OFF_CTRL, d, r); check(d, CTRL_RST);
    give_verdict();
  end
endmodule
